/* verification/spd_chip_src.sv */
`timescale 1ns/1ps
// Recovery loop model: sample ticks and chip strobes on the bench clock
module spd_chip_src
  import spd_pkg::*;
(
  input wire logic clk,
  output spd_pkg::spd_cdr_s clock_data_recovery
);
  initial clock_data_recovery = '0;
  // One chip strobe; data inverts afterwards so stale values never match
  task automatic chip(input logic v);
    @(posedge clk);
    clock_data_recovery.chip_valid <= 1'b1;
    clock_data_recovery.chip <= v;
    @(posedge clk);
    clock_data_recovery.chip_valid <= 1'b0;
    clock_data_recovery.chip <= ~v;
  endtask
  // Sample ticks two cycles apart, with or without a detected edge
  task automatic samples(input int n, input logic e);
    repeat (n) begin
      @(posedge clk);
      clock_data_recovery.sample <= 1'b1;
      clock_data_recovery.edge_seen <= e;
      @(posedge clk);
      clock_data_recovery.sample <= 1'b0;
      clock_data_recovery.edge_seen <= 1'b0;
    end
  endtask
endmodule

/* verification/spd_start_detect_props.sv */
`timescale 1ns/1ps
module spd_start_detect_props
  import spd_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire spd_pkg::spd_cdr_s CDR_IN,
  input wire spd_pkg::spd_loop_s LOOP_OUT,
  input wire spd_pkg::spd_framer_s FRAMER_OUT,
  input wire spd_pkg::spd_slicer_s SLICER_OUT,
  input wire logic RAW_CHIP_STROBE_OUT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Setup phase of a bus transfer
  sequence apb_setup_s;
    PSEL && !PENABLE;
  endsequence
  // Edge seen on a sixteenth-bit sample
  sequence edge_sample_s;
    CDR_IN.sample && CDR_IN.edge_seen;
  endsequence
  ready_after_setup_a: assert property (apb_setup_s |=> PREADY)
    else $error("ready missing after setup");
  ready_only_access_a: assert property (!(PSEL && !PENABLE) |=> !PREADY)
    else $error("ready outside access");
  err_with_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  loss_clears_a: assert property (edge_sample_s |-> ##[1:2]
    !LOOP_OUT.sync_loss) else $error("sync loss kept after edge");
  slicer_cv_a: assert property (SLICER_OUT.eom_cv_tuned |->
    SLICER_OUT.chip_mode && !SLICER_OUT.eom_len_tuned
    && !SLICER_OUT.transparent) else $error("slicer decode wrong");
  raw_from_chip_a: assert property (RAW_CHIP_STROBE_OUT |->
    $past(CDR_IN.chip_valid) && SLICER_OUT.transparent)
    else $error("raw strobe without chip");
  framer_not_raw_a: assert property (FRAMER_OUT.chip_valid |->
    !RAW_CHIP_STROBE_OUT) else $error("framer and raw both active");
  chip_mirror_a: assert property (FRAMER_OUT.chip_valid |->
    $past(CDR_IN.chip_valid)) else $error("framer chip without input");
  start_pulse_a: assert property (FRAMER_OUT.start |=>
    !FRAMER_OUT.start) else $error("start longer than one cycle");
  first_bit_a: assert property (FRAMER_OUT.first_bit_valid |->
    FRAMER_OUT.start) else $error("first bit without start");
  resync_pulse_a: assert property (LOOP_OUT.resync |=>
    !LOOP_OUT.resync) else $error("resync longer than one cycle");
endmodule
bind spd_start_detect spd_start_detect_props u_props (.REF_CLK, .RST,
  .PSEL, .PENABLE, .PREADY, .PSLVERR, .CDR_IN, .LOOP_OUT, .FRAMER_OUT,
  .SLICER_OUT, .RAW_CHIP_STROBE_OUT);

/* verification/spd_start_detect_tb_top.sv */
`timescale 1ns/1ps
`include "spd_params.svh"
module spd_start_detect_tb_top;
  import spd_pkg::*;
  logic clk = 1'b0; // Bench clock, 4 ns
  logic rst = 1'b1; // Held for five cycles
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, raw_d, raw_s, er;
  spd_cdr_s clock_data_recovery;
  spd_loop_s loop_o;
  spd_framer_s fr;
  spd_slicer_s slc;
  int err_total = 0;
  int check_count = 0;
  int rs_cnt = 0; // Resync pulses seen
  spd_start_detect DUT (.REF_CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CDR_IN(clock_data_recovery),
    .LOOP_OUT(loop_o), .FRAMER_OUT(fr), .SLICER_OUT(slc),
    .RAW_CHIP_DATA_OUT(raw_d), .RAW_CHIP_STROBE_OUT(raw_s));
  spd_chip_src src (.clk(clk), .clock_data_recovery(clock_data_recovery));
  initial forever #2 clk = ~clk;
  // Count resync pulses
  always @(posedge clk) if (loop_o.resync === 1'b1) rs_cnt <= rs_cnt + 1;
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // One bus transfer; waits for ready under a bound
  task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_total++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input string n, input logic [9:0] i, input logic [31:0] e);
    apb(1'b0, i, 8'h00);
    chk(n, e, rd);
  endtask
  // Bounded wait for the start pulse
  task wait_start;
    int n;
    n = 0;
    while (fr.start !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    if (fr.start !== 1'b1) begin
      err_total++;
      print_verdict();
    end
  endtask
  // Leaving payload through transparent mode restarts the hunt
  task to_hunt;
    apb(1'b1, `SPD_IDX_SLICER, `SPD_SLC_TRANSP);
    apb(1'b1, `SPD_IDX_SLICER, `SPD_SLC_CHIP_CV);
  endtask
  task t_reset;
    rchk("slicer", `SPD_IDX_SLICER, 32'(`SPD_RST_SLICER));
    rchk("mode", `SPD_IDX_MODE, 32'(`SPD_RST_MODE));
    rchk("len_a", `SPD_IDX_LENA, 32'(`SPD_RST_LENA));
    rchk("window", `SPD_IDX_WINDOW, 32'(`SPD_RST_WINDOW));
    apb(1'b0, 10'h3ff, 8'h00);
    chk("unmapped_err", 32'h1, 32'(er));
    chk("unmapped_data", 32'h0, rd);
    $display("t_reset done");
  endtask
  task t_slicer;
    // Bit mode value included for decode only
    logic [7:0] v[4] = '{8'h90, 8'h94, 8'h75, 8'h95};
    logic [4:0] x[4] = '{5'b10100, 5'b10010, 5'b01000, 5'b10001};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `SPD_IDX_SLICER, v[i]);
      repeat (2) @(posedge clk);
      chk("slicer_out", 32'(x[i]), 32'(slc));
    end
    for (int b = 0; b < 2; b++) begin
      src.chip(b[0]);
      #1;
      chk("raw_strobe", 32'h1, 32'(raw_s));
      chk("raw_data", 32'(b[0]), 32'(raw_d));
    end
    $display("t_slicer done");
  endtask
  task t_par;
    apb(1'b1, `SPD_IDX_SLICER, `SPD_SLC_CHIP_CV);
    apb(1'b1, `SPD_IDX_LENA, 8'h02);
    apb(1'b1, `SPD_IDX_PTA0, 8'h02);
    apb(1'b1, `SPD_IDX_MODE, 8'h0d);
    src.chip(1'b1);
    src.chip(1'b1);
    wait_start();
    chk("par_first_valid", 32'h0, 32'(fr.first_bit_valid));
    chk("readjust", 32'h1, 32'(loop_o.phase_readjust));
    src.chip(1'b0);
    #1;
    chk("payload_valid", 32'h1, 32'(fr.chip_valid));
    chk("payload_chip", 32'h0, 32'(fr.chip));
    to_hunt();
    $display("t_par done");
  endtask
  task t_ext;
    apb(1'b1, `SPD_IDX_LENB, 8'h02);
    apb(1'b1, `SPD_IDX_PTB0, 8'h01);
    apb(1'b1, `SPD_IDX_MODE, 8'h03);
    for (int k = 0; k < 2; k++) begin
      src.chip(k[0]);
      src.chip(~k[0]);
      wait_start();
      chk("ext_valid", 32'h1, 32'(fr.first_bit_valid));
      chk("ext_bit", 32'(!k[0]), 32'(fr.first_bit));
      chk("polarity", 32'(!k[0]), 32'(loop_o.code_polarity));
      to_hunt();
    end
    $display("t_ext done");
  endtask
  task t_gap;
    int r0;
    apb(1'b1, `SPD_IDX_WINDOW, 8'hff);
    apb(1'b1, `SPD_IDX_LENA, 8'h01);
    apb(1'b1, `SPD_IDX_PTA0, 8'h01);
    apb(1'b1, `SPD_IDX_LENB, 8'h01);
    apb(1'b1, `SPD_IDX_PTB0, 8'h00);
    apb(1'b1, `SPD_IDX_GAP, 8'h08);
    apb(1'b1, `SPD_IDX_MODE, 8'h82);
    r0 = rs_cnt;
    src.chip(1'b1);
    @(posedge clk);
    #1;
    chk("gap_hold", 32'h1, 32'(loop_o.hold));
    src.samples(10, 1'b1);
    src.chip(1'b0);
    wait_start();
    chk("gap_resync", 32'h1, 32'(rs_cnt - r0));
    to_hunt();
    $display("t_gap done");
  endtask
  // Full-length A, then B; resync bit set but mode 00 has no gap
  task t_seq;
    int r0;
    apb(1'b1, `SPD_IDX_LENA, 8'h10);
    apb(1'b1, `SPD_IDX_PTA0, 8'h00);
    apb(1'b1, `SPD_IDX_LENB, 8'h01);
    apb(1'b1, `SPD_IDX_PTB0, 8'h01);
    apb(1'b1, `SPD_IDX_MODE, 8'h80);
    r0 = rs_cnt;
    repeat (16) src.chip(1'b0);
    apb(1'b0, `SPD_IDX_STATUS, 8'h00);
    chk("seq_wait_b", 32'h1, 32'(rd[2:1]));
    src.chip(1'b1);
    wait_start();
    chk("seq_no_resync", 32'h0, 32'(rs_cnt - r0));
    to_hunt();
    $display("t_seq done");
  endtask
  task t_loss;
    apb(1'b1, `SPD_IDX_WINDOW, 8'h03);
    src.samples(1, 1'b1);
    src.samples(3, 1'b0);
    repeat (3) @(posedge clk);
    chk("loss_at_window", 32'h0, 32'(loop_o.sync_loss));
    src.samples(1, 1'b0);
    repeat (3) @(posedge clk);
    chk("loss_above", 32'h1, 32'(loop_o.sync_loss));
    apb(1'b0, `SPD_IDX_STATUS, 8'h00);
    chk("status_loss", 32'h1, 32'(rd[0]));
    src.samples(1, 1'b1);
    repeat (3) @(posedge clk);
    chk("loss_cleared", 32'h0, 32'(loop_o.sync_loss));
    $display("t_loss done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_slicer();
    t_par();
    t_ext();
    t_gap();
    t_seq();
    t_loss();
    print_verdict();
  end
endmodule

/* verilog/spd_params.svh */
`ifndef SPD_PARAMS_SVH
`define SPD_PARAMS_SVH
// Register indexes; byte address is four times the index
`define SPD_IDX_SLICER 10'h04c
`define SPD_IDX_MODE 10'h04d
`define SPD_IDX_LENA 10'h04e
`define SPD_IDX_LENB 10'h04f
`define SPD_IDX_GAP 10'h050
`define SPD_IDX_PTA0 10'h051
`define SPD_IDX_PTA1 10'h052
`define SPD_IDX_PTB0 10'h053
`define SPD_IDX_PTB1 10'h054
`define SPD_IDX_WINDOW 10'h05e
`define SPD_IDX_STATUS 10'h05f
// Reset values
`define SPD_RST_SLICER 8'h90
`define SPD_RST_MODE 8'h80
`define SPD_RST_LENA 5'h00
`define SPD_RST_LENB 5'h00
`define SPD_RST_GAP 8'h00
`define SPD_RST_PAT 16'h0000
`define SPD_RST_WINDOW 8'h28
// Slicer settings
`define SPD_SLC_CHIP_CV 8'h90
`define SPD_SLC_CHIP_LEN 8'h94
`define SPD_SLC_TRANSP 8'h95
`define SPD_SLC_BIT 8'h75
// Mode register fields
`define SPD_MODE_RESYNC 7
`define SPD_MODE_WCA_HI 6
`define SPD_MODE_WCA_LO 3
`define SPD_MODE_READJ 2
// Gap register fields
`define SPD_GAP_COARSE_HI 7
`define SPD_GAP_COARSE_LO 3
`define SPD_GAP_FINE_HI 2
// Lengths and timing
`define SPD_LEN_MAX 5'h10
`define SPD_SAMPLES_PER_HALF 3
`define SPD_CNT_MAX 8'hff
`endif

/* verilog/spd_pkg.sv */
package spd_pkg;
  // Detection modes
  typedef enum logic [1:0] {
    SPD_DET_SEQ = 2'b00,
    SPD_DET_PAR = 2'b01,
    SPD_DET_GAP = 2'b10,
    SPD_DET_EXT = 2'b11
  } spd_det_e;
  // Hunt states, Gray along hunt, wait, gap, payload
  typedef enum logic [1:0] {
    SPD_HUNT = 2'b00,
    SPD_WAIT_B = 2'b01,
    SPD_GAP = 2'b11,
    SPD_PAYLOAD = 2'b10
  } spd_state_e;
  // Chip stream from the recovery loop
  typedef struct packed {
    logic sample;
    logic edge_seen;
    logic chip_valid;
    logic chip;
  } spd_cdr_s;
  // Control back to the recovery loop
  typedef struct packed {
    logic sync_loss;
    logic hold;
    logic resync;
    logic phase_readjust;
    logic code_polarity;
  } spd_loop_s;
  // Stream toward the framer
  typedef struct packed {
    logic start;
    logic first_bit_valid;
    logic first_bit;
    logic chip_valid;
    logic chip;
  } spd_framer_s;
  // Slicer mode decode
  typedef struct packed {
    logic chip_mode;
    logic bit_mode;
    logic eom_cv_tuned;
    logic eom_len_tuned;
    logic transparent;
  } spd_slicer_s;
endpackage

/* verilog/spd_start_detect.sv */
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "spd_params.svh"
// Functional notes
// - Loss of sync when edgeless count exceeds window
// - 90h and 94h select chip modes
// - 95h transparent: chips to raw outputs
// - Gap resync bit only in mode 2
// - Resync off: gap from coarse and fine
// - Resync on: T/2 gap, then resync loop
// - Bits 6:3 wildcard four LSB chips of A
// - Readjust bit picks payload code phase handling
// - Mode 00: A then B, B conditional
// - Mode 01: A or B in parallel
// - Mode 10: A, gap, then B
// - Mode 11: A or B, first bit tells which
// - Pattern A length 1 to 16 chips
// - Coarse gap holds loop lock after A
// - Pattern B length 0 only in mode 00
module spd_start_detect (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire spd_pkg::spd_cdr_s CDR_IN,
  output spd_pkg::spd_loop_s LOOP_OUT,
  output spd_pkg::spd_framer_s FRAMER_OUT,
  output spd_pkg::spd_slicer_s SLICER_OUT,
  output logic RAW_CHIP_DATA_OUT,
  output logic RAW_CHIP_STROBE_OUT
);
  import spd_pkg::*;

  // Mask of the lowest len chips; out-of-range lengths match nothing
  function automatic logic [15:0] len_mask(input logic [4:0] len);
    logic [16:0] m;
    m = (17'h00001 << len) - 17'h00001;
    len_mask = (len > `SPD_LEN_MAX) ? 16'h0000 : m[15:0];
  endfunction

  // Software registers
  logic [7:0] slicer_mode_select;
  logic [7:0] start_pattern_detect_mode;
  logic [4:0] pattern_a_length;
  logic [4:0] pattern_b_length;
  logic [7:0] gap_reg;
  logic [15:0] pattern_a;
  logic [15:0] pattern_b;
  logic [7:0] edge_timeout_window;

  // Detection state
  spd_state_e state;
  spd_state_e next_state;
  logic [15:0] chips; // Newest chip in bit 0
  logic [4:0] fill; // Chips seen since hunt restart or B search start
  logic new_chip; // Chip strobe last cycle with no restart
  logic [7:0] edge_cnt; // Samples without edge
  logic [7:0] gap_cnt;
  logic matched_b;

  // APB decode
  wire [9:0] idx = PADDR[11:2];
  wire setup = PSEL && !PENABLE;
  wire wr_en = PSEL && PENABLE && PREADY && PWRITE;
  wire hit_slicer = idx == `SPD_IDX_SLICER;
  wire hit_mode = idx == `SPD_IDX_MODE;
  wire hit_lena = idx == `SPD_IDX_LENA;
  wire hit_lenb = idx == `SPD_IDX_LENB;
  wire hit_gap = idx == `SPD_IDX_GAP;
  wire hit_pta0 = idx == `SPD_IDX_PTA0;
  wire hit_pta1 = idx == `SPD_IDX_PTA1;
  wire hit_ptb0 = idx == `SPD_IDX_PTB0;
  wire hit_ptb1 = idx == `SPD_IDX_PTB1;
  wire hit_win = idx == `SPD_IDX_WINDOW;
  wire hit_stat = idx == `SPD_IDX_STATUS;
  wire mapped = hit_slicer | hit_mode | hit_lena | hit_lenb | hit_gap |
                hit_pta0 | hit_pta1 | hit_ptb0 | hit_ptb1 | hit_win |
                hit_stat;
  // Status: sync loss, state, which pattern matched
  wire [7:0] status = {4'h0, matched_b, state, LOOP_OUT.sync_loss};
  wire [7:0] rd_byte =
    hit_slicer ? slicer_mode_select :
    hit_mode ? start_pattern_detect_mode :
    hit_lena ? {3'h0, pattern_a_length} :
    hit_lenb ? {3'h0, pattern_b_length} :
    hit_gap ? gap_reg :
    hit_pta0 ? pattern_a[7:0] :
    hit_pta1 ? pattern_a[15:8] :
    hit_ptb0 ? pattern_b[7:0] :
    hit_ptb1 ? pattern_b[15:8] :
    hit_win ? edge_timeout_window :
    hit_stat ? status : 8'h00;

  // Field views
  wire gap_resync_enable = start_pattern_detect_mode[`SPD_MODE_RESYNC];
  wire [3:0] correlator_a_wildcards =
    start_pattern_detect_mode[`SPD_MODE_WCA_HI:`SPD_MODE_WCA_LO];
  wire payload_phase_readjust =
    start_pattern_detect_mode[`SPD_MODE_READJ];
  wire [1:0] pattern_detect_mode = start_pattern_detect_mode[1:0];
  wire [4:0] coarse_gap_time =
    gap_reg[`SPD_GAP_COARSE_HI:`SPD_GAP_COARSE_LO];
  wire [2:0] fine_gap_time = gap_reg[`SPD_GAP_FINE_HI:0];

  // Slicer decode
  wire slc_cv = slicer_mode_select == `SPD_SLC_CHIP_CV;
  wire slc_len = slicer_mode_select == `SPD_SLC_CHIP_LEN;
  wire slc_tr = slicer_mode_select == `SPD_SLC_TRANSP;
  wire slc_bit = slicer_mode_select == `SPD_SLC_BIT;

  // Correlators on the newest chips
  wire [15:0] mask_a = len_mask(pattern_a_length) &
                       ~{12'h000, correlator_a_wildcards};
  wire [15:0] mask_b = len_mask(pattern_b_length);
  wire a_ok = new_chip && pattern_a_length != 5'h00 &&
              fill >= pattern_a_length &&
              ((chips ^ pattern_a) & mask_a) == 16'h0000;
  // B length zero never matches, except it skips B in mode 00
  wire b_ok = new_chip && pattern_b_length != 5'h00 &&
              fill >= pattern_b_length &&
              ((chips ^ pattern_b) & mask_b) == 16'h0000;
  // Mode 00 uses B only for a full A and a nonzero B
  wire seq_b_used = pattern_a_length == `SPD_LEN_MAX &&
                    pattern_b_length != 5'h00;
  // Gap length in sixteenths
  wire [7:0] coarse_16 = {coarse_gap_time, 3'h0};
  wire [7:0] gap_len = gap_resync_enable ? coarse_16
                     : coarse_16 + {5'h00, fine_gap_time};
  wire gap_done = gap_cnt >= gap_len;
  wire loss_now = edge_cnt > edge_timeout_window;
  wire start_now = state != SPD_PAYLOAD && next_state == SPD_PAYLOAD;
  // History restarts on entering or leaving hunt, and while bypassed
  wire restart = slc_tr || ((state == SPD_HUNT) != (next_state == SPD_HUNT));
  wire b_side = (state == SPD_HUNT) ? (b_ok && !a_ok) : b_ok;

  // Next state of the hunt
  always_comb begin
    next_state = state;
    case (state)
      SPD_HUNT: begin
        if (slc_tr) begin
          next_state = SPD_HUNT; // Framer bypassed, no hunt
        end else if (pattern_detect_mode == SPD_DET_PAR ||
                     pattern_detect_mode == SPD_DET_EXT) begin
          if (a_ok || b_ok) begin
            next_state = SPD_PAYLOAD;
          end
        end else if (a_ok) begin
          if (pattern_detect_mode == SPD_DET_GAP) begin
            next_state = SPD_GAP;
          end else if (seq_b_used) begin
            next_state = SPD_WAIT_B;
          end else begin
            next_state = SPD_PAYLOAD;
          end
        end
      end
      SPD_WAIT_B: begin
        if (loss_now || slc_tr) begin
          next_state = SPD_HUNT;
        end else if (b_ok) begin
          next_state = SPD_PAYLOAD;
        end
      end
      SPD_GAP: begin
        if (gap_done) begin
          next_state = SPD_WAIT_B;
        end
      end
      SPD_PAYLOAD: begin
        // Payload ends on loss or transparent mode; the framer owns other ends
        if (loss_now || slc_tr) begin
          next_state = SPD_HUNT;
        end
      end
      default: begin
        next_state = SPD_HUNT;
      end
    endcase
  end

  // APB handshake: no wait state, data and error from flops
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && !mapped;
      PRDATA <= (setup && !PWRITE) ? {24'h000000, rd_byte} : 32'h0;
    end
  end

  // Register writes, low byte only
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      slicer_mode_select <= `SPD_RST_SLICER;
      start_pattern_detect_mode <= `SPD_RST_MODE;
      pattern_a_length <= `SPD_RST_LENA;
      pattern_b_length <= `SPD_RST_LENB;
      gap_reg <= `SPD_RST_GAP;
      pattern_a <= `SPD_RST_PAT;
      pattern_b <= `SPD_RST_PAT;
      edge_timeout_window <= `SPD_RST_WINDOW;
    end else if (wr_en) begin
      if (hit_slicer) slicer_mode_select <= PWDATA[7:0];
      if (hit_mode) start_pattern_detect_mode <= PWDATA[7:0];
      if (hit_lena) pattern_a_length <= PWDATA[4:0];
      if (hit_lenb) pattern_b_length <= PWDATA[4:0];
      if (hit_gap) gap_reg <= PWDATA[7:0];
      if (hit_pta0) pattern_a[7:0] <= PWDATA[7:0];
      if (hit_pta1) pattern_a[15:8] <= PWDATA[7:0];
      if (hit_ptb0) pattern_b[7:0] <= PWDATA[7:0];
      if (hit_ptb1) pattern_b[15:8] <= PWDATA[7:0];
      if (hit_win) edge_timeout_window <= PWDATA[7:0];
    end
  end

  // Edgeless sample counter, saturating
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      edge_cnt <= 8'h00;
    end else if (CDR_IN.sample) begin
      if (CDR_IN.edge_seen || state == SPD_GAP) begin
        edge_cnt <= 8'h00; // Loop is held locked over the gap
      end else if (edge_cnt != `SPD_CNT_MAX) begin
        edge_cnt <= edge_cnt + 8'h01;
      end
    end
  end

  // Chip history; fill count cleared at each hunt or B search start
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      chips <= 16'h0000;
      fill <= 5'h00;
      new_chip <= 1'b0;
    end else begin
      new_chip <= CDR_IN.chip_valid && !restart;
      if (restart || next_state == SPD_WAIT_B && state != SPD_WAIT_B)
      begin
        fill <= 5'h00;
      end else if (CDR_IN.chip_valid) begin
        chips <= {chips[14:0], CDR_IN.chip};
        if (fill != `SPD_LEN_MAX) fill <= fill + 5'h01;
      end
    end
  end

  // State, gap timer and match memory
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state <= SPD_HUNT;
      gap_cnt <= 8'h00;
      matched_b <= 1'b0;
    end else begin
      state <= next_state;
      if (state != SPD_GAP) begin
        gap_cnt <= 8'h00;
      end else if (CDR_IN.sample) begin
        gap_cnt <= gap_cnt + 8'h01;
      end
      if (start_now) matched_b <= b_side;
    end
  end

  // Loop control toward clock and data recovery
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      LOOP_OUT <= '0;
    end else begin
      LOOP_OUT.sync_loss <= loss_now;
      LOOP_OUT.hold <= next_state == SPD_GAP;
      // Resync flag counts only in gap mode, since only it has a gap
      LOOP_OUT.resync <= state == SPD_GAP && gap_done &&
                         gap_resync_enable;
      LOOP_OUT.phase_readjust <= payload_phase_readjust;
      if (start_now) begin
        LOOP_OUT.code_polarity <= chips[0];
      end
    end
  end

  // Framer stream and raw transparent outputs
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      FRAMER_OUT <= '0;
      SLICER_OUT <= '0;
      RAW_CHIP_DATA_OUT <= 1'b0;
      RAW_CHIP_STROBE_OUT <= 1'b0;
    end else begin
      FRAMER_OUT.start <= start_now;
      FRAMER_OUT.first_bit_valid <= start_now &&
        pattern_detect_mode == SPD_DET_EXT;
      FRAMER_OUT.first_bit <= b_side;
      FRAMER_OUT.chip_valid <= state == SPD_PAYLOAD &&
                               CDR_IN.chip_valid && !slc_tr;
      FRAMER_OUT.chip <= CDR_IN.chip;
      SLICER_OUT.chip_mode <= slc_cv | slc_len | slc_tr;
      SLICER_OUT.bit_mode <= slc_bit;
      SLICER_OUT.eom_cv_tuned <= slc_cv;
      SLICER_OUT.eom_len_tuned <= slc_len;
      SLICER_OUT.transparent <= slc_tr;
      RAW_CHIP_DATA_OUT <= slc_tr & CDR_IN.chip;
      RAW_CHIP_STROBE_OUT <= slc_tr & CDR_IN.chip_valid;
    end
  end
endmodule
